// File: src/bsc_pkg.sv
// constants for the back-emf constant decode and start-path selection
// assumes a single 100 MHz clock and an ahb-lite register bus
// What this block does
// [R1] back-emf constant held as 7 bits: 3-bit shift high, 4-bit mantissa low.
// [R2] software multiplies measured constant in V/Hz by 1090 before encoding.
// [R3] magnitude decodes as mantissa shifted left by the shift field.
// [R4] all-ones code decodes to 1920, the largest programmable constant.
// [R5] code one decodes to one, the smallest nonzero constant.
// [R6] before start the motor is classed stationary, forward or reverse.
// [R7] stationary motor gets commutation aligned to rotor before driving on.
// [R8] stationary start offers inductive position detect or forced align.
// [R9] fast forward motor may resync straight into closed-loop drive.
// [R10] reverse drive decelerates through zero speed then accelerates forward.
// [R11] reverse without reverse drive either waits for stop or brakes.
// [R12] once a reverse motor stops the stationary start path follows.
// [R13] software picks reverse-drive or brake settings that limit current and surge.
// [R14] second comparator lagging means forward, leading means reverse.
// [R15] speed below selected stationary threshold means motor is stationary.
// [R16] reverse speed above its threshold returns to detection to coast down.
// [R17] brake only when brake duration field nonzero, for the selected time.
package bsc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] BSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] BSC_STAT_ADDR = 8'h04;
    localparam logic [31:0] BSC_CTRL_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int BSC_CODE_LO = 0;
    localparam int BSC_MANT_W = 4;
    localparam int BSC_SHIFT_W = 3;
    localparam int BSC_CODE_W = BSC_MANT_W + BSC_SHIFT_W;
    localparam int BSC_STILL_LO = 7;
    localparam int BSC_REV_LO = 9;
    localparam int BSC_THR_W = 2;
    localparam int BSC_BRAKE_LO = 11;
    localparam int BSC_BRAKE_W = 3;
    localparam int BSC_DETECT_EN = 14;
    localparam int BSC_REVDRV_EN = 15;
    localparam int BSC_IPD_EN = 16;
    localparam int BSC_START_EN = 17;
    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int BSC_MAG_W = 11;
    localparam int BSC_ST_STATE_LO = 0;
    localparam int BSC_ST_COND_LO = 3;
    localparam int BSC_ST_MAG_LO = 5;
    localparam logic [BSC_MAG_W-1:0] BSC_MAG_MAX = 11'h780;
    localparam logic [1:0] BSC_HTRANS_NONSEQ = 2'h2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BSC_IDLE = 3'h0,
        BSC_DETECT = 3'h1,
        BSC_BRAKE = 3'h2,
        BSC_ALIGN = 3'h3,
        BSC_IPD = 3'h4,
        BSC_REVDRIVE = 3'h5,
        BSC_ACCEL = 3'h6,
        BSC_CLOSED = 3'h7
    } bsc_state_t;
    typedef enum logic [1:0] {
        BSC_STILL = 2'h0,
        BSC_FWD = 2'h1,
        BSC_REV = 2'h2,
        BSC_UNKNOWN = 2'h3
    } bsc_cond_t;
endpackage

// File: src/bsc_start_select.sv
// back-emf constant decode and start-path sequencer with ahb-lite registers
// assumes comparator pins asynchronous, phaseDone from same-clock drive logic
`timescale 1ns/1ps
module bsc_start_select import bsc_pkg::*; #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] STILL_LIM0 = 24'h00C350,
    parameter logic [CNT_W-1:0] STILL_LIM1 = 24'h0186A0,
    parameter logic [CNT_W-1:0] STILL_LIM2 = 24'h030D40,
    parameter logic [CNT_W-1:0] STILL_LIM3 = 24'h061A80,
    parameter logic [CNT_W-1:0] REV_LIM0 = 24'h004E20,
    parameter logic [CNT_W-1:0] REV_LIM1 = 24'h002710,
    parameter logic [CNT_W-1:0] REV_LIM2 = 24'h001388,
    parameter logic [CNT_W-1:0] REV_LIM3 = 24'h0009C4,
    parameter logic [CNT_W-1:0] BRAKE_UNIT = 24'h0186A0
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // motor side
    input wire logic cmpUv,
    input wire logic cmpUw,
    input wire logic phaseDone,
    output logic [2:0] driveMode,
    output logic [BSC_MAG_W-1:0] bemfMagnitude
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic wrPend;
    logic [7:0] wrAddr;
    bsc_state_t state;
    bsc_cond_t cond;
    wire addrPhase = hsel && hready && (htrans == BSC_HTRANS_NONSEQ);
    wire ctrlHit = (haddr == BSC_CTRL_ADDR);
    wire statHit = (haddr == BSC_STAT_ADDR);
    wire [31:0] statWord = {{(32 - BSC_ST_MAG_LO - BSC_MAG_W){1'b0}}, bemfMagnitude,
        cond, state};
    wire [31:0] next_rdata = ctrlHit ? ctrl : (statHit ? statWord : 32'h0000_0000);
    wire ctrlWrite = wrPend && (wrAddr == BSC_CTRL_ADDR);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            ctrl <= BSC_CTRL_RESET;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr;
            if (addrPhase && !hwrite) begin
                hrdata <= next_rdata;
            end
            if (ctrlWrite) begin
                ctrl <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire [BSC_CODE_W-1:0] bemfCode = ctrl[BSC_CODE_LO +: BSC_CODE_W]; // [R1]
    wire [BSC_MANT_W-1:0] mantissa = bemfCode[BSC_MANT_W-1:0]; // [R1]
    wire [BSC_SHIFT_W-1:0] shiftAmt = bemfCode[BSC_CODE_W-1:BSC_MANT_W]; // [R1]
    wire [BSC_MAG_W-1:0] next_magnitude =
        {{(BSC_MAG_W - BSC_MANT_W){1'b0}}, mantissa} << shiftAmt; // [R3] [R4] [R5]
    wire [1:0] stillThr = ctrl[BSC_STILL_LO +: BSC_THR_W];
    wire [1:0] revThr = ctrl[BSC_REV_LO +: BSC_THR_W];
    wire [2:0] brakeDur = ctrl[BSC_BRAKE_LO +: BSC_BRAKE_W];
    wire detectEn = ctrl[BSC_DETECT_EN];
    wire revDriveEn = ctrl[BSC_REVDRV_EN];
    wire ipdEn = ctrl[BSC_IPD_EN];
    wire startEn = ctrl[BSC_START_EN];
    wire brakeEn = (brakeDur != 3'h0); // [R17]
    wire [CNT_W-1:0] stillLim = (stillThr == 2'h0) ? STILL_LIM0 :
        (stillThr == 2'h1) ? STILL_LIM1 : (stillThr == 2'h2) ? STILL_LIM2 : STILL_LIM3;
    wire [CNT_W-1:0] revLim = (revThr == 2'h0) ? REV_LIM0 :
        (revThr == 2'h1) ? REV_LIM1 : (revThr == 2'h2) ? REV_LIM2 : REV_LIM3;
    wire [CNT_W-1:0] brakeLoad = CNT_W'(brakeDur * BRAKE_UNIT); // [R17]

    // ------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------
    logic [2:0] uvSync;
    logic [2:0] uwSync;
    logic uvLevel;
    logic uwLevel;
    wire uvStable = (uvSync[1] == uvSync[2]);
    wire uwStable = (uwSync[1] == uwSync[2]);
    wire uvRise = uvStable && uvSync[2] && !uvLevel;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uvSync <= 3'h0;
            uwSync <= 3'h0;
            uvLevel <= 1'b0;
            uwLevel <= 1'b0;
        end else if (ce) begin
            uvSync <= {uvSync[1:0], cmpUv};
            uwSync <= {uwSync[1:0], cmpUw};
            if (uvStable) begin
                uvLevel <= uvSync[2];
            end
            if (uwStable) begin
                uwLevel <= uwSync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // speed and direction detection
    // ------------------------------------------------------------
    logic [CNT_W-1:0] period;
    logic seenEdge;
    logic [CNT_W-1:0] brakeCnt;
    wire measureDone = (state == BSC_DETECT) && uvRise && seenEdge;
    wire stillTimeout = (state == BSC_DETECT) && (period >= stillLim); // [R15]
    wire fastEnough = (period < stillLim); // [R15]
    // uw low at uv rise: uw lags by 60 degrees, so forward
    wire dirReverse = uwLevel; // [R14]
    wire revTooFast = (period < revLim); // [R16]
    bsc_state_t next_state;
    bsc_cond_t next_cond;
    bsc_state_t stillPath;

    assign stillPath = brakeEn ? BSC_BRAKE : (ipdEn ? BSC_IPD : BSC_ALIGN); // [R7] [R8]

    always_comb begin
        next_state = state;
        next_cond = cond;
        unique case (state)
            BSC_IDLE: begin
                if (startEn) begin
                    next_state = detectEn ? BSC_DETECT : stillPath;
                    next_cond = detectEn ? BSC_UNKNOWN : BSC_STILL;
                end
            end
            BSC_DETECT: begin
                if (stillTimeout) begin
                    next_cond = BSC_STILL; // [R6] [R15]
                    next_state = stillPath; // [R12]
                end else if (measureDone && fastEnough) begin
                    next_cond = dirReverse ? BSC_REV : BSC_FWD; // [R6] [R14]
                    if (!dirReverse) begin
                        next_state = BSC_CLOSED; // [R9]
                    end else if (revTooFast) begin
                        next_state = BSC_DETECT; // [R16]
                    end else if (revDriveEn) begin
                        next_state = BSC_REVDRIVE; // [R10]
                    end else if (brakeEn) begin
                        next_state = BSC_BRAKE; // [R11]
                    end else begin
                        next_state = BSC_DETECT; // [R11]
                    end
                end
            end
            BSC_BRAKE: begin
                if (brakeCnt == '0) begin
                    next_state = ipdEn ? BSC_IPD : BSC_ALIGN; // [R12] [R17]
                end
            end
            BSC_ALIGN, BSC_IPD: begin
                if (phaseDone) begin
                    next_state = BSC_ACCEL; // [R7]
                end
            end
            BSC_REVDRIVE: begin
                if (phaseDone) begin
                    next_state = BSC_ACCEL; // [R10]
                end
            end
            BSC_ACCEL: begin
                if (phaseDone) begin
                    next_state = BSC_CLOSED;
                end
            end
            BSC_CLOSED: begin
                next_state = BSC_CLOSED;
            end
        endcase
        if (!startEn) begin
            next_state = BSC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= BSC_IDLE;
            cond <= BSC_UNKNOWN;
            period <= '0;
            seenEdge <= 1'b0;
            brakeCnt <= '0;
            driveMode <= BSC_IDLE;
            bemfMagnitude <= '0;
        end else if (ce) begin
            state <= next_state;
            cond <= next_cond;
            driveMode <= next_state;
            bemfMagnitude <= next_magnitude; // [R3]
            if (state != BSC_DETECT || uvRise) begin
                period <= '0;
            end else if (!stillTimeout) begin
                period <= period + 1'b1;
            end
            seenEdge <= (state == BSC_DETECT) && (seenEdge || uvRise);
            if (state != BSC_BRAKE) begin
                // the cycle that reads zero is the last braking cycle
                brakeCnt <= brakeLoad - CNT_W'(1); // [R17]
            end else if (brakeCnt != '0) begin
                brakeCnt <= brakeCnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    magnitude_decode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        ce && $stable(ctrl) |=> bemfMagnitude ==
            ({{(BSC_MAG_W - BSC_MANT_W){1'b0}}, $past(mantissa)} << $past(shiftAmt)))
        else $error("magnitude does not match decoded code");
    magnitude_max_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        ce && bemfCode == 7'h7F |=> bemfMagnitude == BSC_MAG_MAX)
        else $error("all-ones code not 1920");
    magnitude_min_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        ce && bemfCode == 7'h01 |=> bemfMagnitude == 11'h001)
        else $error("code one not one");
    forward_resync_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        ce && startEn && measureDone && fastEnough && !dirReverse
        |=> state == BSC_CLOSED && cond == BSC_FWD)
        else $error("forward motor not resynced");
    reverse_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        ce && startEn && measureDone && fastEnough && dirReverse && !revTooFast
            && revDriveEn |=> state == BSC_REVDRIVE)
        else $error("reverse drive not entered");
    reverse_fast_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        ce && startEn && measureDone && fastEnough && dirReverse && revTooFast
        |=> state == BSC_DETECT)
        else $error("fast reverse motor not left to coast");
    brake_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        $rose(state == BSC_BRAKE) |-> $past(brakeDur) != 3'h0)
        else $error("brake entered with zero duration");
    still_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        ce && startEn && stillTimeout && !brakeEn
        |=> (state == BSC_IPD || state == BSC_ALIGN) && cond == BSC_STILL)
        else $error("stationary motor not initialised");
    brake_after_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        ce && startEn && state == BSC_BRAKE && brakeCnt == '0
        |=> state == (ipdEn ? BSC_IPD : BSC_ALIGN))
        else $error("brake not followed by stationary path");
    mode_output_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !startEn |=> driveMode == BSC_IDLE && state == BSC_IDLE)
        else $error("cleared start did not force idle");
endmodule

// File: test/bsc_motor_model.sv
// motor stand-in: comparator pair and drive completion pulses
// assumes bsc_pkg state codes on driveMode and a synchronous active-low reset
`timescale 1ns/1ps
module bsc_motor_model import bsc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // scenario knobs
    input wire logic spin,
    input wire logic rev,
    input wire logic [7:0] halfPer,
    input wire logic [7:0] lag,
    // drive side
    input wire logic [2:0] driveMode,
    output logic cmpUv,
    output logic cmpUw,
    output logic phaseDone
);
    logic [8:0] ph;
    logic [8:0] per;
    logic [8:0] sixth;
    logic [8:0] uwPh;
    logic [7:0] waitCnt;
    logic busy;
    assign per = {halfPer, 1'b0};
    assign sixth = {1'b0, halfPer / 8'h03};
    assign busy = driveMode inside {BSC_ALIGN, BSC_IPD, BSC_REVDRIVE, BSC_ACCEL};
    // uw lags uv by a sixth turn forward, leads it in reverse
    assign uwPh = rev ? (ph + sixth) % per : (ph + per - sixth) % per;
    assign cmpUv = spin && (ph < {1'b0, halfPer});
    assign cmpUw = spin && (uwPh < {1'b0, halfPer});
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph <= 9'h000;
            waitCnt <= 8'h00;
            phaseDone <= 1'b0;
        end else begin
            ph <= (ph + 9'h001 >= per) ? 9'h000 : ph + 9'h001;
            phaseDone <= busy && !phaseDone && waitCnt == lag;
            waitCnt <= (busy && !phaseDone && waitCnt != lag) ? waitCnt + 8'h01 : 8'h00;
        end
    end
endmodule

// File: test/bsc_start_select_tb.sv
// self-checking bench for the back-emf decode and start-path selector
// assumes bsc_pkg, the motor stand-in and a 100 MHz clock
`timescale 1ns/1ps
module bsc_start_select_tb import bsc_pkg::*; ;
    typedef struct packed {
        logic [6:0] code;
        logic [10:0] mag;
    } bsc_row_t;
    localparam bsc_row_t ROWS [7] = '{
        '{7'h00, 11'h000},
        '{7'h01, 11'h001},
        '{7'h7F, 11'h780},
        '{7'h28, 11'h020},
        '{7'h18, 11'h010},
        '{7'h5F, 11'h1E0},
        '{7'h7A, 11'h500}
    };
    localparam logic [31:0] GO = (32'h1 << BSC_START_EN) | (32'h1 << BSC_DETECT_EN);
    localparam logic [31:0] RVD = 32'h1 << BSC_REVDRV_EN;
    localparam logic [31:0] POSDET = 32'h1 << BSC_IPD_EN;
    localparam logic [31:0] BRK3 = 32'h3 << BSC_BRAKE_LO;
    localparam logic [31:0] STILL3 = 32'h3 << BSC_STILL_LO;
    logic clk, rst_n, ce, hsel, hwrite, hready, hreadyout, hresp;
    logic cmpUv, cmpUw, phaseDone, spin, rev, clrSeen;
    logic [7:0] haddr, halfPer, lag, seen, brakeCnt;
    logic [1:0] htrans;
    logic [2:0] hsize, driveMode;
    logic [31:0] hwdata, hrdata, rd;
    logic [10:0] bemfMagnitude;
    int n_fail, checks_done;
    assign hready = hreadyout;
    bsc_start_select #(.STILL_LIM0(24'h000028), .STILL_LIM3(24'h000064),
        .REV_LIM0(24'h00000A), .BRAKE_UNIT(24'h000008)) bsc_start_select_inst (
        .clk(clk), .rst_n(rst_n),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmpUv(cmpUv), .cmpUw(cmpUw),
        .phaseDone(phaseDone), .driveMode(driveMode), .bemfMagnitude(bemfMagnitude));
    bsc_motor_model bsc_motor_model_inst (.clk(clk), .rst_n(rst_n), .spin(spin),
        .rev(rev), .halfPer(halfPer), .lag(lag), .driveMode(driveMode),
        .cmpUv(cmpUv), .cmpUw(cmpUw), .phaseDone(phaseDone));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // path tracking and shared tasks
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (clrSeen) begin
            seen <= 8'h00;
            brakeCnt <= 8'h00;
        end else begin
            seen[driveMode] <= 1'b1;
            brakeCnt <= brakeCnt + 8'(driveMode == BSC_BRAKE);
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        chk(32'(hready), 32'h1);
        if (hready !== 1'b1) begin
            end_sim();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= BSC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        tick_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        tick_ready();
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    task automatic wait_mode(input logic [2:0] target);
        int n;
        n = 0;
        while (driveMode !== target && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(driveMode), 32'(target));
        if (driveMode !== target) begin
            end_sim();
        end
        @(posedge clk);
        $display("reached mode %0d", target);
    endtask
    task automatic scen(input logic [31:0] cfg, input logic sp, input logic rv,
            input logic [7:0] hp, input logic [2:0] target);
        spin <= sp;
        rev <= rv;
        halfPer <= hp;
        bus(1'b1, BSC_CTRL_ADDR, 32'h0);
        clrSeen <= 1'b1;
        bus(1'b1, BSC_CTRL_ADDR, cfg);
        clrSeen <= 1'b0;
        wait_mode(target);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, hsel, hwrite, spin, rev, clrSeen, htrans, haddr, hwdata} = '0;
        {ce, hsize, halfPer, lag, n_fail, checks_done} = {1'b1, 3'h2, 8'h09, 8'h03, 64'h0};
        repeat (8) @(posedge clk);
        chk({17'h0, hreadyout, driveMode, bemfMagnitude}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, BSC_CTRL_ADDR, 32'h0);
        chk(rd, BSC_CTRL_RESET);
        foreach (ROWS[i]) begin
            bus(1'b1, BSC_CTRL_ADDR, {25'h0, ROWS[i].code});
            bus(1'b0, BSC_CTRL_ADDR, 32'h0);
            chk(rd, {25'h0, ROWS[i].code});
            bus(1'b0, BSC_STAT_ADDR, 32'h0);
            chk(32'(rd[BSC_ST_MAG_LO +: BSC_MAG_W]), 32'(ROWS[i].mag));
            chk(32'(bemfMagnitude), 32'(ROWS[i].mag));
        end
        // clock enable low: the write is lost and outputs hold
        ce <= 1'b0;
        bus(1'b1, BSC_CTRL_ADDR, 32'h0);
        ce <= 1'b1;
        chk(32'(bemfMagnitude), 32'h500);
        bus(1'b1, BSC_STAT_ADDR, 32'hFFFF_FFFF);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, BSC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h7A);
        $display("register tests done");
        scen(GO, 1'b0, 1'b0, 8'h09, BSC_CLOSED);
        chk(32'(seen), 32'hCB);
        lag <= 8'h28;
        scen(GO | POSDET, 1'b0, 1'b0, 8'h09, BSC_CLOSED);
        chk(32'(seen), 32'hD3);
        lag <= 8'h03;
        scen(GO, 1'b1, 1'b0, 8'h09, BSC_CLOSED);
        chk(32'(seen), 32'h83);
        bus(1'b0, BSC_STAT_ADDR, 32'h0);
        chk(32'(rd[BSC_ST_COND_LO +: 2]), 32'(BSC_FWD));
        scen(GO | RVD, 1'b1, 1'b1, 8'h09, BSC_CLOSED);
        chk(32'(seen), 32'hE3);
        bus(1'b0, BSC_STAT_ADDR, 32'h0);
        chk(32'(rd[BSC_ST_COND_LO +: 2]), 32'(BSC_REV));
        // brake for a short fixed time keeps returned energy small
        scen(GO | BRK3, 1'b1, 1'b1, 8'h09, BSC_CLOSED);
        chk(32'(seen), 32'hCF);
        chk(32'(brakeCnt), 32'h18);
        scen(GO, 1'b1, 1'b0, 8'h19, BSC_CLOSED);
        chk(32'(seen), 32'hCB);
        scen(GO | STILL3, 1'b1, 1'b0, 8'h19, BSC_CLOSED);
        chk(32'(seen), 32'h83);
        scen(GO | RVD, 1'b1, 1'b1, 8'h04, BSC_DETECT);
        repeat (60) @(posedge clk);
        chk(32'(driveMode), 32'(BSC_DETECT));
        halfPer <= 8'h09;
        wait_mode(BSC_CLOSED);
        chk(32'(seen), 32'hE3);
        scen(GO, 1'b1, 1'b1, 8'h09, BSC_DETECT);
        repeat (60) @(posedge clk);
        chk(32'(driveMode), 32'(BSC_DETECT));
        spin <= 1'b0;
        wait_mode(BSC_CLOSED);
        chk(32'(seen), 32'hCB);
        scen(32'h1 << BSC_START_EN, 1'b1, 1'b0, 8'h09, BSC_CLOSED);
        chk(32'(seen[BSC_ALIGN]), 32'h1);
        bus(1'b1, BSC_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(driveMode), 32'(BSC_IDLE));
        scen(GO, 1'b1, 1'b1, 8'h09, BSC_DETECT);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(hreadyout), 32'h0);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(32'(driveMode), 32'(BSC_IDLE));
        bus(1'b0, BSC_CTRL_ADDR, 32'h0);
        chk(rd, BSC_CTRL_RESET);
        $display("reset tests done");
        end_sim();
    end
endmodule
